// >>> pkg/rtc_pkg.sv
// rtc_pkg: constants and types shared by both ends of the rt control link
// assumes a single 250 MHz pclk on both ends
package rtc_pkg;
  // clock and derived timing counts
  localparam int CLK_HZ = 250_000_000;
  localparam int STROBE_NS = 500;
  localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int FAILSAFE_MS = 730;
  localparam int FAILSAFE_CYC = FAILSAFE_MS * (CLK_HZ / 1000);
  localparam int AUX_HZ = 2_000_000;
  localparam int AUX_HALF_CYC = CLK_HZ / (2 * AUX_HZ);
  localparam int HOST_HOLD_CYC = 4;
  // device register indices on the host pins
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_TADDR = 3'h1;
  localparam logic [2:0] REG_STAT = 3'h2;
  localparam int CTRL_PRST_BIT = 0;
  localparam int TADDR_W = 5;
  localparam logic [15:0] REG_RST = 16'h0000;
  // host controller apb offsets
  localparam logic [11:0] A_CMD = 12'h000;
  localparam logic [11:0] A_CTRL = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [11:0] A_PINS = 12'h00C;
  // command register fields
  localparam int CMD_SEL_LSB = 16;
  localparam int CMD_READ_BIT = 19;
  localparam int CMD_MEM_BIT = 20;
  localparam int CMD_GO_BIT = 31;
  // host control register fields
  localparam int HC_BCAST = 0;
  localparam int HC_REJECT = 1;
  localparam int HC_ADDR = 2;
  localparam int HC_INIT = 3;
  localparam logic [3:0] HCTRL_RST = 4'h0;
  // host pin sequencer states
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_DRIVE = 2'b01,
    HS_GAP   = 2'b10
  } rtc_hst_e;
endpackage

// >>> pkg/rtc_if.sv
// rtc_if: control and status pins between host and rt device
// assumes both ends on pclk; data bus idles high when nobody drives
`timescale 1ns/1ps
interface rtc_if;
  logic        cs_n;
  logic        ctrl_n;
  logic        rd_wr;
  logic [2:0]  reg_sel;
  logic [15:0] host_data;
  logic        host_data_oe_n;
  logic [15:0] dev_data;
  logic        dev_data_oe_n;
  logic [15:0] data_bus;
  logic        addr_bus_drive_n;
  logic        bcast_accept_n;
  logic        host_reject_command;
  logic        master_init_n;
  logic        ram_select_n;
  logic        ram_read_write;
  logic [15:0] addr_out;
  logic        addr_oe_n;
  logic        valid_command_pulse_n;
  logic        failsafe_pulse_n;
  logic        message_fault;
  logic        channel_indicator;
  logic        transmit_active_n;
  logic        receive_active_n;
  logic        bcast_received_n;
  logic        status_word;
  logic        mode_or_sub_flag;
  logic [4:0]  command_field_out;
  logic        clk_2mhz;

  // resolved shared data bus, pulled high when idle
  assign data_bus = !dev_data_oe_n  ? dev_data :
                    !host_data_oe_n ? host_data : 16'hFFFF;

  modport dev (
    input  cs_n, ctrl_n, rd_wr, reg_sel, data_bus, addr_bus_drive_n,
    input  bcast_accept_n, host_reject_command, master_init_n,
    output dev_data, dev_data_oe_n, ram_select_n, ram_read_write,
    output addr_out, addr_oe_n, valid_command_pulse_n, failsafe_pulse_n,
    output message_fault, channel_indicator, transmit_active_n,
    output receive_active_n, bcast_received_n, status_word,
    output mode_or_sub_flag, command_field_out, clk_2mhz
  );
  modport hst (
    output cs_n, ctrl_n, rd_wr, reg_sel, host_data, host_data_oe_n,
    output addr_bus_drive_n, bcast_accept_n, host_reject_command,
    output master_init_n,
    input  data_bus, ram_select_n, ram_read_write, addr_out, addr_oe_n,
    input  valid_command_pulse_n, failsafe_pulse_n, message_fault,
    input  channel_indicator, transmit_active_n, receive_active_n,
    input  bcast_received_n, status_word, mode_or_sub_flag,
    input  command_field_out, clk_2mhz
  );
endinterface

// >>> src/rtc_device.sv
// rtc_device: rt device end of the control pins and discrete status
// assumes core events arrive as one-cycle pulses on pclk
`timescale 1ns/1ps
module rtc_device #(
  parameter int FAILSAFE_CYC = rtc_pkg::FAILSAFE_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // pins toward host and ram
  rtc_if.dev               link,
  // command events from the protocol core
  input  wire logic        cmd_valid,
  input  wire logic        cmd_chan_a,
  input  wire logic        cmd_bcast,
  input  wire logic        cmd_mode,
  input  wire logic [4:0]  cmd_field,
  input  wire logic        msg_error,
  // activity levels from the protocol core
  input  wire logic        transmit_active_n_busy,
  input  wire logic        rcv_busy,
  input  wire logic        status_tx,
  input  wire logic        self_test,
  input  wire logic        transparent,
  // memory requests from the dma engine
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [15:0] mem_addr,
  // results toward the protocol core
  output logic             cmd_accepted,
  output logic             prog_reset,
  output logic [4:0]       term_addr,
  output logic             host_rejected
);
  localparam int SW = $clog2(rtc_pkg::STROBE_CYC + 1);
  localparam int FW = $clog2(FAILSAFE_CYC + 1);
  localparam int AW = $clog2(rtc_pkg::AUX_HALF_CYC + 1);

  logic [15:0]   regs_q [8];
  logic [15:0]   rd_data_q;
  logic          wr_prev_q;
  logic          prst_q;
  logic [SW-1:0] stb_cnt_q;
  logic [FW-1:0] fs_cnt_q;
  logic          status_q;
  logic          fault_q;
  logic          chan_q;
  logic          bcast_q;
  logic          mode_q;
  logic [4:0]    field_q;
  logic          tx_q;
  logic          rx_q;
  logic [15:0]   addr_q;
  logic [AW-1:0] aux_cnt_q;
  logic          aux_q;

  // init from the master pin or a programmed reset
  wire init = !link.master_init_n || prst_q;

  // host pin decode
  wire reg_acc  = !link.cs_n && !link.ctrl_n;
  wire reg_rd   = reg_acc && link.rd_wr;
  wire reg_wr   = reg_acc && !link.rd_wr;
  wire wr_first = reg_wr && !wr_prev_q;
  wire sel_ctrl = link.reg_sel == rtc_pkg::REG_CTRL;
  wire sel_stat = link.reg_sel == rtc_pkg::REG_STAT;
  wire prst_d   = wr_first && sel_ctrl &&
                  link.data_bus[rtc_pkg::CTRL_PRST_BIT];

  // command acceptance and event decode
  wire accept = cmd_valid && (!cmd_bcast || !link.bcast_accept_n);
  wire reject = link.host_reject_command && (transmit_active_n_busy || rcv_busy);
  wire fault_set = msg_error || reject;
  wire status_rise = status_tx && !status_q;
  wire fs_cut = accept && !self_test;

  // readable status word
  wire [15:0] stat_word = {4'h0, field_q, mode_q, !tx_q, !rx_q, bcast_q,
                           fs_cnt_q != '0, chan_q, fault_q};
  wire [15:0] rd_mux = sel_stat ? stat_word :
                       sel_ctrl ? 16'h0000 : regs_q[link.reg_sel];

  // register file writes; status and control hold nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        regs_q[i] <= rtc_pkg::REG_RST;
    end
    else if (init)
    begin
      for (int i = 0; i < 8; i++)
        regs_q[i] <= rtc_pkg::REG_RST;
    end
    else if (reg_wr && !sel_stat && !sel_ctrl)
      regs_q[link.reg_sel] <= link.data_bus;
  end

  // read data register, write edge and programmed reset pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_data_q <= 16'h0000;
      wr_prev_q <= 1'b0;
      prst_q    <= 1'b0;
    end
    else
    begin
      rd_data_q <= rd_mux;
      wr_prev_q <= reg_wr;
      prst_q    <= prst_d && !prst_q;
    end
  end

  // command strobe timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stb_cnt_q <= '0;
    else if (init)
      stb_cnt_q <= '0;
    else if (accept)
      stb_cnt_q <= SW'(rtc_pkg::STROBE_CYC);
    else if (stb_cnt_q != '0)
      stb_cnt_q <= stb_cnt_q - SW'(1);
  end

  // failsafe timer; a start beats a cut in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fs_cnt_q <= '0;
    else if (init)
      fs_cnt_q <= '0;
    else if (status_rise)
      fs_cnt_q <= FW'(FAILSAFE_CYC);
    else if (fs_cut)
      fs_cnt_q <= '0;
    else if (fs_cnt_q != '0)
      fs_cnt_q <= fs_cnt_q - FW'(1);
  end

  // message fault: set beats clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_q <= 1'b0;
    else if (init)
      fault_q <= 1'b0;
    else if (fault_set)
      fault_q <= 1'b1;
    else if (accept)
      fault_q <= 1'b0;
  end

  // latched facts of the most recent accepted command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_q  <= 1'b0;
      bcast_q <= 1'b0;
      mode_q  <= 1'b0;
      field_q <= 5'h00;
    end
    else if (init)
    begin
      chan_q  <= 1'b0;
      bcast_q <= 1'b0;
      mode_q  <= 1'b0;
      field_q <= 5'h00;
    end
    else if (accept)
    begin
      chan_q  <= cmd_chan_a;
      bcast_q <= cmd_bcast;
      mode_q  <= !cmd_mode;
      field_q <= cmd_field;
    end
  end

  // activity levels and memory address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= 1'b0;
      tx_q     <= 1'b0;
      rx_q     <= 1'b0;
      addr_q   <= 16'h0000;
    end
    else
    begin
      status_q <= status_tx && !init;
      tx_q     <= transmit_active_n_busy && !init;
      rx_q     <= rcv_busy && !init;
      addr_q   <= mem_addr;
    end
  end

  // 2 MHz output, held low while init
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_cnt_q <= '0;
      aux_q     <= 1'b0;
    end
    else if (init)
    begin
      aux_cnt_q <= '0;
      aux_q     <= 1'b0;
    end
    else if (aux_cnt_q == AW'(rtc_pkg::AUX_HALF_CYC - 1))
    begin
      aux_cnt_q <= '0;
      aux_q     <= !aux_q;
    end
    else
      aux_cnt_q <= aux_cnt_q + AW'(1);
  end

  // ram strobes: pass-through in transparent mode, dma otherwise
  assign link.ram_select_n = transparent ? link.cs_n : !mem_req;
  assign link.ram_read_write = transparent ? link.rd_wr :
                               !(mem_req && mem_write);

  // pin outputs
  assign link.dev_data              = rd_data_q;
  assign link.dev_data_oe_n         = !reg_rd;
  assign link.addr_out              = addr_q;
  assign link.addr_oe_n             = link.addr_bus_drive_n;
  assign link.valid_command_pulse_n = stb_cnt_q == '0;
  assign link.failsafe_pulse_n      = fs_cnt_q == '0;
  assign link.message_fault         = fault_q;
  assign link.channel_indicator     = chan_q;
  assign link.transmit_active_n     = !tx_q;
  assign link.receive_active_n      = !rx_q;
  assign link.bcast_received_n      = !bcast_q;
  assign link.status_word           = status_q;
  assign link.mode_or_sub_flag      = mode_q;
  assign link.command_field_out     = field_q;
  assign link.clk_2mhz              = aux_q;

  // core side results
  assign cmd_accepted  = accept && !init;
  assign prog_reset    = prst_q;
  assign term_addr     = regs_q[rtc_pkg::REG_TADDR][rtc_pkg::TADDR_W-1:0];
  assign host_rejected = link.host_reject_command;
endmodule

// >>> src/rtc_host.sv
// rtc_host: host controller end, runs pin cycles ordered over apb
// assumes an apb master on pclk; pready is always high
`timescale 1ns/1ps
module rtc_host (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins toward the device
  rtc_if.hst               link
);
  rtc_pkg::rtc_hst_e state_q;
  logic [3:0]  ctrl_q;
  logic [2:0]  cnt_q;
  logic [15:0] rdata_q;
  logic [31:0] prdata_q;
  logic        cs_n_q;
  logic        ctrl_n_q;
  logic        rd_wr_q;
  logic [2:0]  sel_q;
  logic [15:0] wdata_q;
  logic        oe_n_q;

  // apb decode
  wire hit_cmd  = paddr == rtc_pkg::A_CMD;
  wire hit_ctrl = paddr == rtc_pkg::A_CTRL;
  wire hit_stat = paddr == rtc_pkg::A_STAT;
  wire hit_pins = paddr == rtc_pkg::A_PINS;
  wire mapped   = hit_cmd || hit_ctrl || hit_stat || hit_pins;
  wire setup    = psel && !penable;
  wire wr_acc   = psel && penable && pwrite && mapped;
  wire busy     = state_q != rtc_pkg::HS_IDLE;
  wire start    = wr_acc && hit_cmd && pwdata[rtc_pkg::CMD_GO_BIT] && !busy;
  wire is_read  = pwdata[rtc_pkg::CMD_READ_BIT];

  // snapshot of the device status pins
  wire [15:0] pins = {link.ram_select_n, link.ram_read_write,
                      link.command_field_out, link.mode_or_sub_flag,
                      link.bcast_received_n, link.receive_active_n,
                      link.transmit_active_n, link.channel_indicator,
                      link.message_fault, link.failsafe_pulse_n,
                      link.valid_command_pulse_n, link.status_word};

  // read data mux
  wire [31:0] rd_mux =
    hit_cmd  ? {11'h000, ctrl_n_q, rd_wr_q, sel_q, wdata_q} :
    hit_ctrl ? {28'h0000000, ctrl_q} :
    hit_stat ? {rdata_q, 15'h0000, busy} :
    hit_pins ? {16'h0000, pins} : 32'h00000000;

  // apb read data and control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h00000000;
      ctrl_q   <= rtc_pkg::HCTRL_RST;
    end
    else
    begin
      if (setup)
        prdata_q <= rd_mux;
      if (wr_acc && hit_ctrl)
        ctrl_q <= pwdata[3:0];
    end
  end

  // pin sequencer: drive, hold, sample, release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= rtc_pkg::HS_IDLE;
      cnt_q    <= 3'h0;
      rdata_q  <= 16'h0000;
      cs_n_q   <= 1'b1;
      ctrl_n_q <= 1'b1;
      rd_wr_q  <= 1'b1;
      sel_q    <= 3'h0;
      wdata_q  <= 16'h0000;
      oe_n_q   <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        rtc_pkg::HS_IDLE:
          if (start)
          begin
            state_q  <= rtc_pkg::HS_DRIVE;
            cnt_q    <= 3'(rtc_pkg::HOST_HOLD_CYC - 1);
            cs_n_q   <= 1'b0;
            ctrl_n_q <= pwdata[rtc_pkg::CMD_MEM_BIT];
            rd_wr_q  <= is_read;
            sel_q    <= pwdata[rtc_pkg::CMD_SEL_LSB +: 3];
            wdata_q  <= pwdata[15:0];
            oe_n_q   <= is_read;
          end
        rtc_pkg::HS_DRIVE:
          if (cnt_q == 3'h0)
          begin
            state_q  <= rtc_pkg::HS_GAP;
            if (rd_wr_q)
              rdata_q <= link.data_bus;
            cs_n_q   <= 1'b1;
            ctrl_n_q <= 1'b1;
            rd_wr_q  <= 1'b1;
            oe_n_q   <= 1'b1;
          end
          else
            cnt_q <= cnt_q - 3'h1;
        rtc_pkg::HS_GAP:
          state_q <= rtc_pkg::HS_IDLE;
        default:
          state_q <= rtc_pkg::HS_IDLE;
      endcase
    end
  end

  // apb answer
  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // pin outputs
  assign link.cs_n                = cs_n_q;
  assign link.ctrl_n              = ctrl_n_q;
  assign link.rd_wr               = rd_wr_q;
  assign link.reg_sel             = sel_q;
  assign link.host_data           = wdata_q;
  assign link.host_data_oe_n      = oe_n_q;
  assign link.bcast_accept_n      = !ctrl_q[rtc_pkg::HC_BCAST];
  assign link.host_reject_command = ctrl_q[rtc_pkg::HC_REJECT];
  assign link.addr_bus_drive_n    = !ctrl_q[rtc_pkg::HC_ADDR];
  assign link.master_init_n       = !ctrl_q[rtc_pkg::HC_INIT];
endmodule

// >>> testbench/rtc_chk.sv
// rtc_chk: timing checks on the pins between host and device ends
// assumes one pclk domain; presetn resets both ends
`timescale 1ns/1ps
module rtc_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // host levels
  input wire logic cs_n,
  input wire logic ctrl_n,
  input wire logic rd_wr,
  input wire logic addr_bus_drive_n,
  input wire logic master_init_n,
  // device outputs
  input wire logic dev_data_oe_n,
  input wire logic ram_select_n,
  input wire logic ram_read_write,
  input wire logic addr_oe_n,
  input wire logic valid_command_pulse_n,
  input wire logic failsafe_pulse_n,
  input wire logic message_fault,
  input wire logic status_word,
  input wire logic clk_2mhz
);
  logic [15:0] low_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // cycles the command strobe has stayed low
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_q <= 16'h0000;
    else
      low_q <= valid_command_pulse_n ? 16'h0000 : low_q + 16'h0001;

  // properties on the link
  property p_addr_oe;
    addr_oe_n == addr_bus_drive_n;
  endproperty
  property p_strobe_len;
    $rose(valid_command_pulse_n) && $past(master_init_n) |-> low_q >= 16'h007D;
  endproperty
  property p_fs_start;
    $rose(status_word) |-> !failsafe_pulse_n;
  endproperty
  property p_init_ends;
    !master_init_n |=> failsafe_pulse_n && valid_command_pulse_n;
  endproperty
  property p_init_clk;
    !master_init_n [*2] |=> !clk_2mhz && !message_fault;
  endproperty
  property p_dev_drive;
    dev_data_oe_n == !(!cs_n && !ctrl_n && rd_wr);
  endproperty
  property p_fault_clear;
    $fell(valid_command_pulse_n) |-> !message_fault;
  endproperty
  property p_ram_idle;
    ram_select_n |-> ram_read_write;
  endproperty

  a_addr_oe: assert property (p_addr_oe)
    else $error("address enable does not follow its input");
  a_strobe_len: assert property (p_strobe_len)
    else $error("command strobe too short");
  a_fs_start: assert property (p_fs_start)
    else $error("failsafe not low at status start");
  a_init_ends: assert property (p_init_ends)
    else $error("init did not end the pulses");
  a_init_clk: assert property (p_init_clk)
    else $error("init did not stop clock or fault");
  a_dev_drive: assert property (p_dev_drive)
    else $error("device data drive wrong");
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault not cleared by command");
  a_ram_idle: assert property (p_ram_idle)
    else $error("ram direction low while unselected");

  // main scenarios reached
  c_cmd: cover property ($fell(valid_command_pulse_n));
  c_fs: cover property ($rose(status_word));
  c_rd: cover property (!dev_data_oe_n);
endmodule

// >>> testbench/test_rt_host_control_status_pins.sv
// test_rt_host_control_status_pins: host and device ends joined by rtc_if
// assumes apb drives the host, the bench plays the protocol core
`timescale 1ns/1ps
module test_rt_host_control_status_pins;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmd_valid = 1'b0;
  logic        cmd_chan_a = 1'b0;
  logic        cmd_bcast = 1'b0;
  logic        cmd_mode = 1'b0;
  logic [4:0]  cmd_field = 5'h00;
  logic        msg_error = 1'b0;
  logic        transmit_active_n_busy = 1'b0;
  logic        rcv_busy = 1'b0;
  logic        status_tx = 1'b0;
  logic        self_test = 1'b0;
  logic        transparent = 1'b0;
  logic        mem_req = 1'b0;
  logic        mem_write = 1'b0;
  logic [15:0] mem_addr = 16'h0000;
  logic [4:0]  term_addr;
  logic        host_rejected;
  logic [31:0] rd;
  logic        err;
  int          n;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #2 pclk = ~pclk;

  // the two ends and the checker
  rtc_if link ();
  rtc_device #(.FAILSAFE_CYC(300)) i_rtc_device (.pclk(pclk),
    .presetn(presetn), .link(link), .cmd_valid(cmd_valid),
    .cmd_chan_a(cmd_chan_a), .cmd_bcast(cmd_bcast), .cmd_mode(cmd_mode),
    .cmd_field(cmd_field), .msg_error(msg_error), .transmit_active_n_busy(transmit_active_n_busy),
    .rcv_busy(rcv_busy), .status_tx(status_tx), .self_test(self_test),
    .transparent(transparent), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .cmd_accepted(), .prog_reset(),
    .term_addr(term_addr), .host_rejected(host_rejected));
  rtc_host i_rtc_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  rtc_chk i_rtc_chk (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
    .ctrl_n(link.ctrl_n), .rd_wr(link.rd_wr),
    .addr_bus_drive_n(link.addr_bus_drive_n),
    .master_init_n(link.master_init_n), .dev_data_oe_n(link.dev_data_oe_n),
    .ram_select_n(link.ram_select_n), .ram_read_write(link.ram_read_write),
    .addr_oe_n(link.addr_oe_n),
    .valid_command_pulse_n(link.valid_command_pulse_n),
    .failsafe_pulse_n(link.failsafe_pulse_n),
    .message_fault(link.message_fault), .status_word(link.status_word),
    .clk_2mhz(link.clk_2mhz));

  // verdict and end of run
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      fail_count++;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  // one apb transfer; read data and error land in rd and err
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // host pin cycle ordered by a command word, then busy polled away
  task automatic run(input logic [31:0] c);
    apb(1'b1, rtc_pkg::A_CMD, c);
    for (int k = 0; k < 40; k++)
    begin
      apb(1'b0, rtc_pkg::A_STAT, 32'h0);
      if (rd[0] === 1'b0)
        break;
    end
  endtask

  task automatic ctl(input logic [3:0] b);
    apb(1'b1, rtc_pkg::A_CTRL, {28'h0, b});
    tick(2);
  endtask

  // core command event: {chan_a, bcast, mode, field}
  task automatic fire(input logic [8:0] c);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    {cmd_chan_a, cmd_bcast, cmd_mode, cmd_field} <= c;
    @(posedge pclk);
    cmd_valid <= 1'b0;
  endtask

  // cycles a strobe (f=0) or the failsafe (f=1) stays low
  task automatic dur(input logic f, output int m);
    m = 0;
    #1;
    for (int k = 0; k < 400; k++)
    begin
      if ((f ? link.failsafe_pulse_n : link.valid_command_pulse_n) === 1'b0)
        m++;
      else if (m > 0)
        break;
      tick(1);
    end
  endtask

  // command, strobe length, then {chan, mode flag, field, bcast_n}
  task automatic cmd(input logic [8:0] c, input logic [7:0] e,
                     input int len);
    fire(c);
    dur(1'b0, n);
    chk(n, len);
    chk({link.channel_indicator, link.mode_or_sub_flag,
         link.command_field_out, link.bcast_received_n}, e);
  endtask

  // cut a hang short
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, rtc_pkg::A_PINS, 32'h0);
    chk(rd, 32'h0000C0E6);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // transparent mode mirrors the host select and direction
    @(posedge pclk);
    transparent <= 1'b1;
    apb(1'b1, rtc_pkg::A_CMD, {13'h1000, 3'h3, 16'h5A3C});
    tick(2);
    chk({link.ram_select_n, link.ram_read_write}, 2'b00);
    run(32'h0);
    @(posedge pclk);
    transparent <= 1'b0;
    for (int i = 3; i < 8; i++)
      run({13'h1000, i[2:0], 16'hC0DE ^ i[15:0]});
    for (int i = 3; i < 8; i++)
    begin
      run({13'h1001, i[2:0], 16'h0000});
      chk(rd[31:16], 16'hC0DE ^ i[15:0]);
    end
    run({13'h1000, 3'h1, 16'h0015});
    chk(term_addr, 5'h15);
    run({13'h1001, 3'h1, 16'h0000});
    chk(rd[20:16], 5'h15);
    run({13'h1000, 3'h0, 16'h0001});
    chk(term_addr, 5'h00);
    run({13'h1001, 3'h3, 16'h0000});
    chk(rd[31:16], 16'h0000);
    // dma-side ram strobes and the address bus enable
    @(posedge pclk);
    {mem_req, mem_write, mem_addr} <= {2'b11, 16'h1234};
    tick(1);
    chk({link.ram_select_n, link.ram_read_write}, 2'b00);
    @(posedge pclk);
    mem_write <= 1'b0;
    tick(1);
    chk({link.ram_select_n, link.ram_read_write}, 2'b01);
    @(posedge pclk);
    mem_req <= 1'b0;
    tick(1);
    chk({link.ram_select_n, link.ram_read_write}, 2'b11);
    ctl(4'h4);
    chk({link.addr_oe_n, link.addr_out}, {1'b0, 16'h1234});
    ctl(4'h0);
    chk(link.addr_oe_n, 1'b1);
    // commands, broadcast refused then accepted
    cmd({3'b101, 5'h1B}, {2'b10, 5'h1B, 1'b1}, 125);
    cmd({3'b010, 5'h05}, {2'b10, 5'h1B, 1'b1}, 0);
    ctl(4'h1);
    cmd({3'b010, 5'h05}, {2'b01, 5'h05, 1'b0}, 125);
    // activity levels and message fault
    @(posedge pclk);
    {transmit_active_n_busy, rcv_busy, msg_error} <= 3'b111;
    @(posedge pclk);
    msg_error <= 1'b0;
    tick(2);
    chk({link.transmit_active_n, link.receive_active_n,
         link.message_fault}, 3'b001);
    cmd({3'b101, 5'h1B}, {2'b10, 5'h1B, 1'b1}, 125);
    chk(link.message_fault, 1'b0);
    ctl(4'h2);
    chk({host_rejected, link.message_fault}, 2'b11);
    ctl(4'h0);
    @(posedge pclk);
    {transmit_active_n_busy, rcv_busy} <= 2'b00;
    // failsafe: full length in self test, then cut by a command
    for (int t = 1; t >= 0; t--)
    begin
      @(posedge pclk);
      {status_tx, self_test} <= {1'b1, t[0]};
      fork
        dur(1'b1, n);
        begin
          tick(20);
          fire({3'b101, 5'h1B});
        end
      join
      chk(link.status_word, 1'b1);
      chk(t ? n == 300 : n < 30, 1'b1);
      @(posedge pclk);
      status_tx <= 1'b0;
      tick(150);
      chk(link.status_word, 1'b0);
    end
    // master init ends the failsafe and holds the 2 MHz clock
    @(posedge pclk);
    status_tx <= 1'b1;
    tick(5);
    chk(link.failsafe_pulse_n, 1'b0);
    ctl(4'h8);
    chk(link.failsafe_pulse_n, 1'b1);
    n = 0;
    for (int k = 0; k < 130; k++)
    begin
      tick(1);
      n += int'(link.clk_2mhz !== 1'b0);
    end
    chk(n, 0);
    @(posedge pclk);
    status_tx <= 1'b0;
    ctl(4'h0);
    // 2 MHz output runs again: one high half period in the window
    n = 0;
    for (int k = 0; k < 130; k++)
    begin
      tick(1);
      n += int'(link.clk_2mhz === 1'b1);
    end
    chk(n, rtc_pkg::AUX_HALF_CYC);
    summarize();
  end
endmodule
